// ==== sdc_map.svh ====
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH
// ----------------------------------------------------------------
// shift register layout
// ----------------------------------------------------------------
`define SDC_SHIFT_W 14
`define SDC_TSEL_W 3
`define SDC_OUTDIV_W 2
`define SDC_LOOP_W 9
`define SDC_TSEL_MSB 13
`define SDC_TSEL_LSB 11
`define SDC_OUTDIV_MSB 10
`define SDC_OUTDIV_LSB 9
`define SDC_LOOP_MSB 8
`define SDC_LOOP_LSB 0
// ----------------------------------------------------------------
// reset values (pins idle high through pullups)
// ----------------------------------------------------------------
`define SDC_SHIFT_RST 14'h0000
`define SDC_LOOP_RST 9'h1ff
`define SDC_OUTDIV_RST 2'h3
`define SDC_TSEL_RST 3'h0
`define SDC_OUTCNT_RST 3'h0
// ----------------------------------------------------------------
// output divider half periods, in source ticks
// ----------------------------------------------------------------
`define SDC_HALF_DIV2 3'h1
`define SDC_HALF_DIV4 3'h2
`define SDC_HALF_DIV8 3'h4
// reference predivider ahead of the phase detector
`define SDC_REF_PREDIV 8
`endif

// ==== sdc_pkg.sv ====
`include "sdc_map.svh"
package sdc_pkg;
	// ----------------------------------------------------------------
	// test output selections
	// ----------------------------------------------------------------
	typedef enum logic [`SDC_TSEL_W-1:0] {
		SDC_T_SHIFT_OUT = 3'h0,
		SDC_T_HIGH = 3'h1,
		SDC_T_REF_TAP = 3'h2,
		SDC_T_LOOP_CNT = 3'h3,
		SDC_T_SYNTH = 3'h4,
		SDC_T_LOW = 3'h5,
		SDC_T_BYPASS = 3'h6,
		SDC_T_SYNTH_DIV4 = 3'h7
	} sdc_tsel_t;
	// ----------------------------------------------------------------
	// output divider select codes
	// ----------------------------------------------------------------
	typedef enum logic [`SDC_OUTDIV_W-1:0] {
		SDC_DIV2 = 2'h0,
		SDC_DIV4 = 2'h1,
		SDC_DIV8 = 2'h2,
		SDC_DIV1 = 2'h3
	} sdc_outdiv_t;
	// whole state of the configuration core except the loop counter
	typedef struct packed {
		logic [`SDC_SHIFT_W-1:0] shift; // serial shift register
		logic [`SDC_LOOP_W-1:0] loop_div; // active loop divider
		sdc_outdiv_t out_div; // active output divider
		sdc_tsel_t tsel; // active test select
		logic sclk_q; // previous serial clock level
		logic pload_q; // previous parallel strobe level
		logic src_q; // previous divider source level
		logic [2:0] out_cnt; // output divider tick count
		logic synth; // synthesized output
		logic div4_half; // second synth edge marker
		logic synth_div4; // synth divided by four
		logic test; // test output
	} sdc_core_state_t;
endpackage : sdc_pkg

// ==== sdc_loop_counter.sv ====
`include "sdc_map.svh"
module sdc_loop_counter #(
	parameter int W = `SDC_LOOP_W
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic tick_in,
	input wire logic [W-1:0] modulus_in,
	output logic pulse_out
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] cnt; // ticks since last pulse
		logic pulse; // high for one source period
	} sdc_lc_state_t;
	sdc_lc_state_t cur;
	sdc_lc_state_t next_cur;
	generate
		if (W < 2)
		begin : g_bad_w
			$error("loop counter width too small");
		end
	endgenerate
	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	// pulse style output, not 50 percent: cheap and glitch free [RULE17]
	always_comb
	begin
		next_cur = cur;
		if (tick_in)
		begin
			// a modulus of zero or one behaves as one
			if (modulus_in <= W'(1) || cur.cnt >= modulus_in - W'(1))
			begin
				next_cur.cnt = '0;
				next_cur.pulse = 1'b1;
			end
			else
			begin
				next_cur.cnt = cur.cnt + W'(1);
				next_cur.pulse = 1'b0;
			end
		end
	end
	// state register
	always_ff @(posedge clock_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			cur <= '0;
		else
			cur <= next_cur;
	end
	assign pulse_out = cur.pulse;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_loop_wrap;
		@(posedge clock_in) disable iff (sys_rst_in)
		(tick_in && modulus_in > W'(1) && cur.cnt == modulus_in - W'(1))
		|=> (pulse_out && cur.cnt == '0);
	endproperty
	a_loop_wrap: assert property (p_loop_wrap) else $error("loop count did not wrap"); // [RULE11]
endmodule : sdc_loop_counter

// ==== sdc_config_core.sv ====
// Functional notes
// [RULE1] parallel strobe rise captures loop and output divider
// [RULE2] parallel strobe low: pins flow straight through
// [RULE3] serial data sampled by serial clock into register
// [RULE4] one shift per serial clock rising edge
// [RULE5] controller keeps parallel strobe high while loading serially; t_refuse shifts and commits a frame with it low
// [RULE6] stream order: test, output divider, loop divider
// [RULE7] each field sent most significant bit first
// [RULE8] commit strobe falling edge loads shifted values
// [RULE9] commit strobe high: latches follow shift register
// [RULE10] output select 00/01/10/11 divides 2/4/8/1
// [RULE11] output is reference/8 times loop over output
// [RULE12] controller keeps loop divider within 200 to 400; t_bypass commits a loop divider of 4
// [RULE13] parallel strobe low forces test select zero
// [RULE14] test select only settable over serial stream
// [RULE15] test select picks the test output source
// [RULE16] bypass: serial clock drives both dividers
// [RULE17] bypass loop counter output need not be 50 percent
// [RULE18] parallel strobe low shows first test bit
// [RULE19] controller limits serial clock to 10 MHz; ser_frame shifts with a 9 cycle period, about 11 MHz
// [RULE20] controller retunes in small frequency steps
// [RULE21] shifting alone never changes active settings
`include "sdc_map.svh"
module sdc_config_core #(
	parameter int LOOP_W = `SDC_LOOP_W,
	parameter int SHIFT_W = `SDC_SHIFT_W
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic serial_clock_in, // shift clock, also bypass clock
	input wire logic serial_data_in, // serial bit stream
	input wire logic serial_commit_in, // commit strobe, active high
	input wire logic parallel_strobe_in, // capture strobe, low = transparent
	input wire logic [LOOP_W-1:0] loop_div_pins_in,
	input wire logic [`SDC_OUTDIV_W-1:0] out_div_pins_in,
	input wire logic vco_clock_in, // oscillator level, sampled
	input wire logic reference_tap_in, // divided reference level
	output logic synthesized_output_out,
	output logic test_out,
	output logic loop_counter_output_out,
	output logic [LOOP_W-1:0] loop_div_out,
	output logic [`SDC_OUTDIV_W-1:0] out_div_out,
	output logic [`SDC_TSEL_W-1:0] test_sel_out
);
	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	generate
		if (LOOP_W != `SDC_LOOP_W || SHIFT_W != `SDC_SHIFT_W)
		begin : g_bad_widths
			$error("field layout is fixed at 3+2+9 bits");
		end
	endgenerate
	// ----------------------------------------------------------------
	// state and edge terms
	// ----------------------------------------------------------------
	sdc_pkg::sdc_core_state_t cur;
	sdc_pkg::sdc_core_state_t next_cur;
	logic bypass; // test select is divider bypass
	logic src; // level that feeds both dividers
	logic tick; // source rising edge
	logic sclk_rise; // serial clock rising edge
	logic pload_rise; // parallel strobe low to high
	logic loop_pulse; // loop counter output
	logic [2:0] half; // output divider half period
	assign bypass = (cur.tsel == sdc_pkg::SDC_T_BYPASS);
	// bypass swaps the source; a switch may cut one source period short
	assign src = bypass ? serial_clock_in : vco_clock_in; // [RULE16]
	assign tick = src & ~cur.src_q;
	assign sclk_rise = serial_clock_in & ~cur.sclk_q; // [RULE4]
	assign pload_rise = parallel_strobe_in & ~cur.pload_q;
	// ----------------------------------------------------------------
	// loop counter, fed by the same source as the output divider
	// ----------------------------------------------------------------
	sdc_loop_counter #(
		.W(LOOP_W)
	) u_loop (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.tick_in(tick),
		.modulus_in(cur.loop_div),
		.pulse_out(loop_pulse)
	);
	// half period per output select
	always_comb
	begin
		half = `SDC_HALF_DIV2;
		unique case (cur.out_div)
			sdc_pkg::SDC_DIV2: half = `SDC_HALF_DIV2; // [RULE10]
			sdc_pkg::SDC_DIV4: half = `SDC_HALF_DIV4;
			sdc_pkg::SDC_DIV8: half = `SDC_HALF_DIV8;
			sdc_pkg::SDC_DIV1: half = `SDC_HALF_DIV2; // unused, source passes through
		endcase
	end
	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_cur = cur;
		next_cur.sclk_q = serial_clock_in;
		next_cur.pload_q = parallel_strobe_in;
		next_cur.src_q = src;
		// shift in at the bottom so the first bit ends at the top [RULE7]
		if (sclk_rise)
			next_cur.shift = {cur.shift[SHIFT_W-2:0], serial_data_in}; // [RULE3]
		// settings: parallel path has priority over serial
		if (!parallel_strobe_in)
		begin
			// transparent parallel latches [RULE2]
			next_cur.loop_div = loop_div_pins_in;
			next_cur.out_div = sdc_pkg::sdc_outdiv_t'(out_div_pins_in);
			// test bits held at zero, no parallel route to them [RULE13]
			next_cur.tsel = sdc_pkg::SDC_T_SHIFT_OUT; // [RULE14]
		end
		else if (pload_rise)
		begin
			// capture the pins on the strobe edge [RULE1]
			next_cur.loop_div = loop_div_pins_in;
			next_cur.out_div = sdc_pkg::sdc_outdiv_t'(out_div_pins_in);
		end
		else if (serial_commit_in)
		begin
			// follow the register while high; last value stays at the fall [RULE9]
			next_cur.tsel = sdc_pkg::sdc_tsel_t'(cur.shift[`SDC_TSEL_MSB:`SDC_TSEL_LSB]); // [RULE6]
			next_cur.out_div = sdc_pkg::sdc_outdiv_t'(
				cur.shift[`SDC_OUTDIV_MSB:`SDC_OUTDIV_LSB]); // [RULE8]
			next_cur.loop_div = cur.shift[`SDC_LOOP_MSB:`SDC_LOOP_LSB];
		end
		// otherwise shifting leaves the active settings alone [RULE21]
		// output divider, 50 percent for the even ratios [RULE11]
		if (cur.out_div == sdc_pkg::SDC_DIV1)
		begin
			next_cur.synth = src;
			next_cur.out_cnt = `SDC_OUTCNT_RST;
		end
		else if (tick)
		begin
			if (cur.out_cnt >= half - 3'h1)
			begin
				next_cur.synth = ~cur.synth;
				next_cur.out_cnt = `SDC_OUTCNT_RST;
			end
			else
				next_cur.out_cnt = cur.out_cnt + 3'h1;
		end
		// divide synth by four: toggle on every second rising edge
		if (next_cur.synth & ~cur.synth)
		begin
			next_cur.div4_half = ~cur.div4_half;
			if (cur.div4_half)
				next_cur.synth_div4 = ~cur.synth_div4;
		end
		// test output source [RULE15]
		unique case (cur.tsel)
			// latch held reset while strobe low shows the top bit [RULE18]
			sdc_pkg::SDC_T_SHIFT_OUT: next_cur.test = cur.shift[SHIFT_W-1];
			sdc_pkg::SDC_T_HIGH: next_cur.test = 1'b1;
			sdc_pkg::SDC_T_REF_TAP: next_cur.test = reference_tap_in;
			sdc_pkg::SDC_T_LOOP_CNT: next_cur.test = loop_pulse;
			sdc_pkg::SDC_T_SYNTH: next_cur.test = cur.synth;
			sdc_pkg::SDC_T_LOW: next_cur.test = 1'b0;
			sdc_pkg::SDC_T_BYPASS: next_cur.test = loop_pulse; // [RULE16]
			sdc_pkg::SDC_T_SYNTH_DIV4: next_cur.test = cur.synth_div4;
		endcase
		if (!parallel_strobe_in)
			next_cur.test = cur.shift[SHIFT_W-1]; // [RULE18]
	end
	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			cur <= '0;
			cur.shift <= `SDC_SHIFT_RST;
			cur.loop_div <= `SDC_LOOP_RST;
			cur.out_div <= sdc_pkg::sdc_outdiv_t'(`SDC_OUTDIV_RST);
			cur.tsel <= sdc_pkg::sdc_tsel_t'(`SDC_TSEL_RST);
			cur.out_cnt <= `SDC_OUTCNT_RST;
		end
		else
			cur <= next_cur;
	end
	// outputs, all from flip-flops
	assign synthesized_output_out = cur.synth;
	assign test_out = cur.test;
	assign loop_counter_output_out = loop_pulse;
	assign loop_div_out = cur.loop_div;
	assign out_div_out = cur.out_div;
	assign test_sel_out = cur.tsel;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_pload_low;
		!parallel_strobe_in;
	endsequence
	sequence s_pload_rise;
		!parallel_strobe_in ##1 parallel_strobe_in;
	endsequence
	sequence s_commit_high;
		parallel_strobe_in && cur.pload_q && serial_commit_in;
	endsequence
	property p_capture;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_pload_rise |=> (loop_div_out == $past(loop_div_pins_in)
			&& out_div_out == $past(out_div_pins_in));
	endproperty
	a_capture: assert property (p_capture) else $error("parallel capture missed"); // [RULE1]
	property p_transparent;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_pload_low |=> loop_div_out == $past(loop_div_pins_in);
	endproperty
	a_transparent: assert property (p_transparent) else $error("pins not passed"); // [RULE2]
	property p_tsel_forced;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_pload_low |=> test_sel_out == 3'h0 ##1 (test_out == $past(cur.shift[SHIFT_W-1]));
	endproperty
	a_tsel_forced: assert property (p_tsel_forced) else $error("test bits not zero"); // [RULE13]
	property p_shift;
		@(posedge clock_in) disable iff (sys_rst_in)
		sclk_rise |=> (cur.shift[0] == $past(serial_data_in)
			&& cur.shift[SHIFT_W-1:1] == $past(cur.shift[SHIFT_W-2:0]));
	endproperty
	a_shift: assert property (p_shift) else $error("shift step wrong"); // [RULE4]
	property p_no_shift;
		@(posedge clock_in) disable iff (sys_rst_in)
		!sclk_rise |=> $stable(cur.shift);
	endproperty
	a_no_shift: assert property (p_no_shift) else $error("shift without clock edge"); // [RULE3]
	property p_commit;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_commit_high |=> (test_sel_out == $past(cur.shift[`SDC_TSEL_MSB:`SDC_TSEL_LSB])
			&& loop_div_out == $past(cur.shift[`SDC_LOOP_MSB:`SDC_LOOP_LSB]));
	endproperty
	a_commit: assert property (p_commit) else $error("commit fields wrong"); // [RULE6]
	property p_hold;
		@(posedge clock_in) disable iff (sys_rst_in)
		(parallel_strobe_in && cur.pload_q && !serial_commit_in)
		|=> ($stable(loop_div_out) && $stable(test_sel_out) && $stable(out_div_out));
	endproperty
	a_hold: assert property (p_hold) else $error("settings moved without strobe"); // [RULE21]
	property p_test_high;
		@(posedge clock_in) disable iff (sys_rst_in)
		(parallel_strobe_in && test_sel_out == 3'h1) |=> test_out;
	endproperty
	a_test_high: assert property (p_test_high) else $error("test not high"); // [RULE15]
	property p_bypass;
		@(posedge clock_in) disable iff (sys_rst_in)
		(parallel_strobe_in && bypass) |=> test_out == $past(loop_pulse);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass test source wrong"); // [RULE16]
	property p_div2;
		@(posedge clock_in) disable iff (sys_rst_in)
		(out_div_out == 2'h0 && tick) |=> synthesized_output_out != $past(cur.synth);
	endproperty
	a_div2: assert property (p_div2) else $error("divide by two missed a toggle"); // [RULE10]
endmodule : sdc_config_core

// ==== sdc_ctl_model.sv ====
module sdc_ctl_model (
	input wire logic clock_in,
	output logic serial_clock_out,
	output logic serial_data_out,
	output logic serial_commit_out,
	output logic parallel_strobe_out,
	output logic [8:0] loop_pins_out,
	output logic [1:0] out_pins_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------
	// idle levels
	// ----------------
	// serial lines sit on pulldowns, divider pins on pullups
	initial
	begin
		serial_clock_out = 1'b0;
		serial_data_out = 1'b0;
		serial_commit_out = 1'b0;
		parallel_strobe_out = 1'b0; // held low through power-up
		loop_pins_out = 9'h1ff;
		out_pins_out = 2'h3;
	end
	// ----------------
	// controller actions
	// ----------------
	// wait n edges, then move just after the last one
	task automatic step(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask : step
	// strobe low lets pins flow, a rising strobe captures them
	task automatic par_set(input logic [8:0] m, input logic [1:0] n, input logic s);
		step(1);
		loop_pins_out = m;
		out_pins_out = n;
		parallel_strobe_out = s;
	endtask : par_set
	// 14 bits, msb first, 9 cycle shift period, about 11 MHz, so above 10 MHz
	task automatic ser_frame(input logic [2:0] t, input logic [1:0] n, input logic [8:0] m);
		logic [13:0] f;
		f = {t, n, m};
		for (int i = 13; i >= 0; i--)
		begin
			step(1);
			serial_data_out = f[i]; // data changes with the falling clock
			serial_clock_out = 1'b0;
			step(4);
			serial_clock_out = 1'b1;
			step(4);
		end
		step(1);
		serial_clock_out = 1'b0;
		serial_data_out = 1'b0; // released, pulldown wins
	endtask : ser_frame
	// 60 ns pulse, shift clock held still meanwhile
	task automatic commit_pulse;
		step(1);
		serial_commit_out = 1'b1;
		step(6);
		serial_commit_out = 1'b0;
	endtask : commit_pulse
	// fast shift clock only as a bypass test clock
	task automatic sclk_burst(input int cnt, input int half);
		repeat (cnt)
		begin
			step(half);
			serial_clock_out = 1'b1;
			step(half);
			serial_clock_out = 1'b0;
		end
	endtask : sclk_burst
endmodule : sdc_ctl_model

// ==== tb.sv ====
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------
	// bench signals
	// ----------------
	logic clock_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic sclk, sdata, commit, strobe, synth, test_line, loop_pulse;
	logic [8:0] loop_pins;
	logic [1:0] out_pins;
	logic vco_clock; // stand-in oscillator level
	logic ref_tap; // stand-in reference tap, half the oscillator rate
	logic [2:0] vco_div = 3'h0; // free running source count
	logic [8:0] loop_div;
	logic [1:0] out_div;
	logic [2:0] test_sel;
	int err_total = 0;
	int checks = 0;
	int s, l, t;
	always #5 clock_in = ~clock_in;
	// oscillator tick every 4 cycles, reference every 8, moved off the edge
	always
	begin
		@(posedge clock_in);
		#1;
		vco_div = vco_div + 3'h1;
	end
	// both levels run free, so the reference input never sits tied
	assign vco_clock = vco_div[1];
	assign ref_tap = vco_div[2];
	sdc_config_core dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.serial_clock_in(sclk), .serial_data_in(sdata), .serial_commit_in(commit),
		.parallel_strobe_in(strobe), .loop_div_pins_in(loop_pins),
		.out_div_pins_in(out_pins), .vco_clock_in(vco_clock), .reference_tap_in(ref_tap),
		.synthesized_output_out(synth), .test_out(test_line),
		.loop_counter_output_out(loop_pulse), .loop_div_out(loop_div),
		.out_div_out(out_div), .test_sel_out(test_sel));
	sdc_ctl_model ctl (.clock_in(clock_in), .serial_clock_out(sclk),
		.serial_data_out(sdata), .serial_commit_out(commit),
		.parallel_strobe_out(strobe), .loop_pins_out(loop_pins),
		.out_pins_out(out_pins));
	// ----------------
	// compare and report
	// ----------------
	task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : cmp
	// edge counts may slip by one at the window ends
	task automatic cmp_rate(input string nm, input int exp, input int got);
		checks++;
		if (got < exp - 1 || got > exp + 1)
		begin
			err_total++;
			$display("mismatch %s expected %0d seen %0d", nm, exp, got);
		end
	endtask : cmp_rate
	task automatic give_verdict;
		if (err_total == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	// rising edges of synth, loop pulse and test output
	task automatic measure(input int cyc);
		logic ps, pl, pt;
		s = 0;
		l = 0;
		t = 0;
		ps = synth;
		pl = loop_pulse;
		pt = test_line;
		repeat (cyc)
		begin
			@(posedge clock_in);
			#1;
			if (synth === 1'b1 && ps === 1'b0) s++;
			if (loop_pulse === 1'b1 && pl === 1'b0) l++;
			if (test_line === 1'b1 && pt === 1'b0) t++;
			ps = synth;
			pl = loop_pulse;
			pt = test_line;
		end
	endtask : measure
	task automatic settings(input logic [8:0] m, input logic [1:0] n, input logic [2:0] ts);
		cmp("loop_div", 16'(m), 16'(loop_div));
		cmp("out_div", 16'(n), 16'(out_div));
		cmp("test_sel", 16'(ts), 16'(test_sel));
	endtask : settings
	// ----------------
	// scenarios
	// ----------------
	task automatic t_parallel;
		ctl.par_set(9'h0c8, 2'h1, 1'b0);
		ctl.step(2);
		settings(9'h0c8, 2'h1, 3'h0);
		ctl.par_set(9'h12c, 2'h2, 1'b0);
		ctl.step(2);
		settings(9'h12c, 2'h2, 3'h0);
		ctl.par_set(9'h12c, 2'h2, 1'b1);
		ctl.par_set(9'h0aa, 2'h0, 1'b1);
		ctl.step(2);
		settings(9'h12c, 2'h2, 3'h0);
	endtask : t_parallel
	task automatic t_serial;
		ctl.ser_frame(3'h1, 2'h1, 9'h106);
		settings(9'h12c, 2'h2, 3'h0);
		ctl.commit_pulse;
		ctl.step(2);
		settings(9'h106, 2'h1, 3'h1);
		cmp("test_out", 16'h1, 16'(test_line));
		// retune by a single loop step, the smallest move on offer
		ctl.ser_frame(3'h1, 2'h1, 9'h107);
		settings(9'h106, 2'h1, 3'h1);
		ctl.commit_pulse;
		ctl.step(2);
		settings(9'h107, 2'h1, 3'h1);
	endtask : t_serial
	// commit while strobe low is ignored, test shows first frame bit
	task automatic t_refuse;
		ctl.par_set(9'h0c8, 2'h0, 1'b0);
		ctl.ser_frame(3'h5, 2'h3, 9'h190);
		ctl.commit_pulse;
		ctl.step(2);
		settings(9'h0c8, 2'h0, 3'h0);
		cmp("test_out", 16'h1, 16'(test_line));
		ctl.par_set(9'h0c8, 2'h0, 1'b1);
	endtask : t_refuse
	task automatic t_static;
		logic [2:0] codes[4] = '{3'h0, 3'h1, 3'h2, 3'h5};
		foreach (codes[i])
		begin
			ctl.ser_frame(codes[i], 2'h3, 9'h0c8);
			ctl.commit_pulse;
			// reference runs free: look two edges after each of its own edges
			@(posedge ref_tap);
			ctl.step(2);
			cmp("test_out", 16'(codes[i] == 3'h1 || codes[i] == 3'h2), 16'(test_line));
			@(negedge ref_tap);
			ctl.step(2);
			cmp("test_out", 16'(codes[i] == 3'h1), 16'(test_line));
		end
	endtask : t_static
	// 8000 cycles hold 2000 oscillator ticks
	task automatic t_dynamic;
		logic [2:0] codes[4] = '{3'h3, 3'h4, 3'h7, 3'h2};
		int exp[4] = '{10, 2000, 500, 1000};
		foreach (codes[i])
		begin
			ctl.ser_frame(codes[i], 2'h3, 9'h0c8);
			ctl.commit_pulse;
			measure(8000);
			cmp_rate("test_edges", exp[i], t);
		end
	endtask : t_dynamic
	task automatic t_rates;
		int ratio[4] = '{2, 4, 8, 1};
		for (int n = 0; n < 4; n++)
		begin
			ctl.par_set(9'h0c8, 2'(n), 1'b0);
			measure(8000);
			cmp_rate("synth_edges", 2000 / ratio[n], s);
			cmp_rate("loop_edges", 10, l);
		end
		ctl.par_set(9'h0c8, 2'h3, 1'b1);
	endtask : t_rates
	// shift clock drives both dividers, loop pulse on test
	task automatic t_bypass;
		ctl.ser_frame(3'h6, 2'h0, 9'h004);
		ctl.commit_pulse;
		fork
			ctl.sclk_burst(40, 2);
			measure(170);
		join
		cmp_rate("synth_edges", 20, s);
		cmp_rate("loop_edges", 10, l);
		cmp_rate("test_edges", 10, t);
	endtask : t_bypass
	// ----------------
	// main sequence and watchdog
	// ----------------
	initial
	begin
		ctl.step(10);
		settings(9'h1ff, 2'h3, 3'h0);
		ctl.step(2);
		sys_rst_in = 1'b0;
		t_parallel;
		t_serial;
		t_refuse;
		t_static;
		t_dynamic;
		t_rates;
		t_bypass;
		give_verdict;
	end
	// the run needs about 70000 cycles
	initial
	begin
		#1000000;
		err_total++;
		give_verdict;
	end
endmodule : tb
